// [rtl/rsim_top.sv]
// Receiver status flags, slip detect and interrupt mask registers
module rsim_top
   import rsim_pkg::*;
#(
   parameter int unsigned FRAME_W = 16
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Receiver status2 flags, bit 0 is buffer transfer done
   input wire logic [RSIM_DW-1:0] stat2_flags_i,
   input wire logic rx_frame_strobe_i,
   input wire logic [FRAME_W-1:0] rx_frame_period_i,
   input wire logic port_a_word_clock_i,
   input wire logic port_b_word_clock_i,
   input wire logic port_a_dir_src_i,
   input wire logic port_b_dir_src_i,
   input wire logic port_a_slave_i,
   input wire logic port_b_slave_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [RSIM_AW-1:0] reg_addr_i,
   input wire logic [RSIM_DW-1:0] reg_wdata_i,
   output logic [RSIM_DW-1:0] reg_rdata_o,
   output logic [RSIM_DW-1:0] stat2_irq_o,
   output logic slip_irq_o,
   output logic buffer_transfer_done_flag_o,
   output logic output_slip_flag_o
);
   logic [RSIM_DW-1:0] mask_one_r, mask_one_nxt;
   logic mask_two_r, mask_two_nxt;
   logic [RSIM_DW-1:0] rdata_r, rdata_nxt;
   logic [RSIM_DW-1:0] irq2_r, irq2_nxt;
   logic slip_irq_r, slip_irq_nxt;
   logic slip_r, slip_nxt;
   logic done_r, done_nxt;
   logic [FRAME_W-1:0] phase_r, phase_nxt;
   logic a_wc_prev_r, a_wc_prev_nxt;
   logic b_wc_prev_r, b_wc_prev_nxt;
   // Edges are ignored until one cycle of history exists
   logic hist_ok_r, hist_ok_nxt;
   logic a_edge, b_edge, slip_allowed, wc_edge, near_frame;
   logic [FRAME_W-1:0] win_cnt;

   function automatic logic [RSIM_DW-1:0] slip_word(input logic f);
      slip_word = RSIM_ZERO;
      slip_word[RSIM_SLIP_BIT] = f;
   endfunction

   always_comb begin
      // R04: slave DIR port
      slip_allowed = (port_a_dir_src_i && port_a_slave_i) ||
                     (!port_a_dir_src_i && port_b_dir_src_i &&
                      port_b_slave_i);
      win_cnt = FRAME_W'((32'(rx_frame_period_i) * RSIM_WIN_PCT)
                         / RSIM_PCT_FULL);
      phase_nxt = rx_frame_strobe_i ? '0 : phase_r + FRAME_W'(1);
      a_wc_prev_nxt = port_a_word_clock_i;
      b_wc_prev_nxt = port_b_word_clock_i;
      hist_ok_nxt = 1'b1;
      a_edge = hist_ok_r && (port_a_word_clock_i != a_wc_prev_r);
      b_edge = hist_ok_r && (port_b_word_clock_i != b_wc_prev_r);
      // R05: port A wins
      // Own history per port, so a change of source is no false edge
      wc_edge = port_a_dir_src_i ? a_edge : b_edge;
      // R06: window test
      // Extra carry bit, so a long period cannot wrap the sum
      near_frame = (phase_r <= win_cnt) ||
                   ({1'b0, phase_r} + {1'b0, win_cnt} >=
                    {1'b0, rx_frame_period_i});
      // R02: slip status
      slip_nxt = slip_allowed && wc_edge && near_frame;
      // R01: done flag
      done_nxt = stat2_flags_i[RSIM_BUF_BIT];
      mask_one_nxt = mask_one_r;
      mask_two_nxt = mask_two_r;
      if (reg_wr_i && reg_addr_i == RSIM_MASK_ONE_ADDR) begin
         // R07: mask write
         mask_one_nxt = reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == RSIM_MASK_TWO_ADDR) begin
         mask_two_nxt = reg_wdata_i[RSIM_SLIP_BIT];
      end
      // R08: status2 gating
      irq2_nxt = stat2_flags_i & mask_one_r;
      // R03: slip gating
      slip_irq_nxt = slip_r && mask_two_r;
      rdata_nxt = rdata_r;
      if (reg_rd_i) begin
         // R09: unmasked status read
         unique case (reg_addr_i)
            RSIM_STAT2_ADDR: rdata_nxt = stat2_flags_i;
            RSIM_SLIP_STAT_ADDR: rdata_nxt = slip_word(slip_r);
            RSIM_MASK_ONE_ADDR: rdata_nxt = mask_one_r;
            RSIM_MASK_TWO_ADDR: rdata_nxt = slip_word(mask_two_r);
            default: rdata_nxt = RSIM_ZERO;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mask_one_r <= RSIM_MASK_RST;
         mask_two_r <= 1'b0;
         rdata_r <= RSIM_ZERO;
         irq2_r <= RSIM_ZERO;
         slip_irq_r <= 1'b0;
         slip_r <= 1'b0;
         done_r <= 1'b0;
         phase_r <= '0;
         a_wc_prev_r <= 1'b0;
         b_wc_prev_r <= 1'b0;
         hist_ok_r <= 1'b0;
      end else begin
         mask_one_r <= mask_one_nxt;
         mask_two_r <= mask_two_nxt;
         rdata_r <= rdata_nxt;
         irq2_r <= irq2_nxt;
         slip_irq_r <= slip_irq_nxt;
         slip_r <= slip_nxt;
         done_r <= done_nxt;
         phase_r <= phase_nxt;
         a_wc_prev_r <= a_wc_prev_nxt;
         b_wc_prev_r <= b_wc_prev_nxt;
         hist_ok_r <= hist_ok_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign stat2_irq_o = irq2_r;
   assign slip_irq_o = slip_irq_r;
   assign buffer_transfer_done_flag_o = done_r;
   assign output_slip_flag_o = slip_r;

   property p_slip_irq_masked;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !mask_two_r |=> !slip_irq_r;
   endproperty
   a_slip_irq_masked: assert property (p_slip_irq_masked) // R03
      else $error("slip irq while masked");
   property p_slip_needs_slave;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !slip_allowed |=> !slip_r;
   endproperty
   a_slip_needs_slave: assert property (p_slip_needs_slave) // R04
      else $error("slip without slave DIR port");
   property p_irq2_gate;
      @(posedge mclk_i) disable iff (!rst_b_i)
      ##1 irq2_r == ($past(stat2_flags_i) & $past(mask_one_r));
   endproperty
   a_irq2_gate: assert property (p_irq2_gate) // R08
      else $error("status2 irq gating wrong");
   property p_done_follow;
      @(posedge mclk_i) disable iff (!rst_b_i)
      stat2_flags_i[RSIM_BUF_BIT] |=> done_r;
   endproperty
   a_done_follow: assert property (p_done_follow) // R01
      else $error("done flag missed");
   property p_mask_write;
      @(posedge mclk_i) disable iff (!rst_b_i)
      reg_wr_i && reg_addr_i == RSIM_MASK_ONE_ADDR
         |=> mask_one_r == $past(reg_wdata_i);
   endproperty
   a_mask_write: assert property (p_mask_write) // R07
      else $error("mask write lost");
   property p_slip_upper_zero;
      @(posedge mclk_i) disable iff (!rst_b_i)
      reg_rd_i && reg_addr_i == RSIM_SLIP_STAT_ADDR
         |=> reg_rdata_o[RSIM_DW-1:1] == '0;
   endproperty
   a_slip_upper_zero: assert property (p_slip_upper_zero) // R02
      else $error("slip status upper bits set");
   property p_slip_irq_follow;
      @(posedge mclk_i) disable iff (!rst_b_i)
      slip_r && mask_two_r |=> slip_irq_r;
   endproperty
   a_slip_irq_follow: assert property (p_slip_irq_follow) // R03
      else $error("enabled slip irq missing");
   property p_porta_wins;
      @(posedge mclk_i) disable iff (!rst_b_i)
      port_a_dir_src_i && !port_a_slave_i |=> !slip_r;
   endproperty
   a_porta_wins: assert property (p_porta_wins) // R05
      else $error("port B tracked while A sourced");
   property p_slip_window;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !near_frame |=> !slip_r;
   endproperty
   a_slip_window: assert property (p_slip_window) // R06
      else $error("slip outside window");
   property p_slip_when_masked;
      @(posedge mclk_i) disable iff (!rst_b_i)
      slip_allowed && wc_edge && near_frame && !mask_two_r |=> slip_r;
   endproperty
   a_slip_when_masked: assert property (p_slip_when_masked) // R09
      else $error("masked slip not flagged");
   property p_done_clear;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !stat2_flags_i[RSIM_BUF_BIT] |=> !done_r;
   endproperty
   a_done_clear: assert property (p_done_clear) // R01
      else $error("done flag stuck");
   property p_portb_track;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !port_a_dir_src_i && port_b_dir_src_i && port_b_slave_i &&
         b_edge && near_frame |=> slip_r;
   endproperty
   a_portb_track: assert property (p_portb_track) // R05
      else $error("port B slip missed");
   property p_porta_ignores_b;
      @(posedge mclk_i) disable iff (!rst_b_i)
      port_a_dir_src_i && !a_edge |=> !slip_r;
   endproperty
   a_porta_ignores_b: assert property (p_porta_ignores_b) // R05
      else $error("port B edge used while A sourced");
   property p_slip_irq_needs_flag;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !slip_r |=> !slip_irq_r;
   endproperty
   a_slip_irq_needs_flag: assert property (p_slip_irq_needs_flag) // R03
      else $error("slip irq without flag");
   c_slip: cover property (@(posedge mclk_i) slip_r);
   c_slip_irq: cover property (@(posedge mclk_i) slip_irq_r);
   c_irq2: cover property (@(posedge mclk_i) |irq2_r);
   c_port_b_slip: cover property (@(posedge mclk_i)
      slip_r && !port_a_dir_src_i);
   c_mask_write: cover property (@(posedge mclk_i)
      reg_wr_i && reg_addr_i == RSIM_MASK_ONE_ADDR);
endmodule // rsim_top

// [rtl/rsim_pkg.sv]
// Constants for the receiver status and interrupt mask block
// Function
// R01: Buffer transfer flag reads 1 once done
// R02: Slip status bit 0, upper bits zero
// R03: Slip interrupt only when 0x17 mask set
// R04: Slip interrupt only for slave-mode DIR port
// R05: One port tracked; both means port A
// R06: Slip flagged when word clock near frame
// R07: Eight mask bits at 0x16, reset masked
// R08: Status2 interrupts gated by 0x16 mask
// R09: Status keeps updating regardless of masks
package rsim_pkg;
   localparam int unsigned RSIM_AW = 7;
   localparam int unsigned RSIM_DW = 8;
   localparam logic [RSIM_AW-1:0] RSIM_STAT2_ADDR = 7'h14;
   localparam logic [RSIM_AW-1:0] RSIM_SLIP_STAT_ADDR = 7'h15;
   localparam logic [RSIM_AW-1:0] RSIM_MASK_ONE_ADDR = 7'h16;
   localparam logic [RSIM_AW-1:0] RSIM_MASK_TWO_ADDR = 7'h17;
   localparam logic [RSIM_DW-1:0] RSIM_MASK_RST = 8'h00;
   localparam logic [RSIM_DW-1:0] RSIM_ZERO = 8'h00;
   localparam int unsigned RSIM_SLIP_BIT = 0;
   localparam int unsigned RSIM_BUF_BIT = 0;
   // Window in percent of frame period around the receiver frame edge
   localparam int unsigned RSIM_WIN_PCT = 5;
   localparam int unsigned RSIM_PCT_FULL = 100;
endpackage : rsim_pkg

// [tb/rsim_host_model.sv]
// Host model driving the parallel control register port
module rsim_host_model
   import rsim_pkg::*;
(
   input wire logic mclk_i,
   input wire logic [RSIM_DW-1:0] rdata_i,
   output logic wr_o,
   output logic rd_o,
   output logic [RSIM_AW-1:0] addr_o,
   output logic [RSIM_DW-1:0] wdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = '0;
      wdata_o = '0;
   end
   task automatic xfer(input logic w, input logic [RSIM_AW-1:0] a,
                       input logic [RSIM_DW-1:0] d,
                       output logic [RSIM_DW-1:0] q);
      wr_o = w;
      rd_o = ~w;
      addr_o = a;
      wdata_o = d;
      @(posedge mclk_i) #1;
      q = rdata_i;
      wr_o = 1'b0;
      rd_o = 1'b0;
      // Idle edge, so strobes never toggle twice in one step
      @(posedge mclk_i) #1;
   endtask
endmodule // rsim_host_model

// [tb/tb_top.sv]
// Testbench for the receiver status and mask block
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import rsim_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] stat2_flags_i = 8'h00;
   logic rx_frame_strobe_i = 1'b0;
   logic [15:0] rx_frame_period_i = 16'h0064;
   logic port_a_word_clock_i = 1'b0, port_b_word_clock_i = 1'b0;
   logic port_a_dir_src_i, port_a_slave_i, port_b_dir_src_i, port_b_slave_i;
   logic reg_wr_i, reg_rd_i, slip_irq_o;
   logic buffer_transfer_done_flag_o, output_slip_flag_o;
   logic [6:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, stat2_irq_o, q;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n_flag = 0;
   int n_irq = 0;
   rsim_top #(.FRAME_W(16)) uut (.mclk_i, .rst_b_i, .stat2_flags_i,
      .rx_frame_strobe_i, .rx_frame_period_i, .port_a_word_clock_i,
      .port_b_word_clock_i, .port_a_dir_src_i, .port_b_dir_src_i,
      .port_a_slave_i, .port_b_slave_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
      .reg_wdata_i, .reg_rdata_o, .stat2_irq_o, .slip_irq_o,
      .buffer_transfer_done_flag_o, .output_slip_flag_o);
   rsim_host_model host (.mclk_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i),
      .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
   always #4 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles++;
      n_flag += int'(output_slip_flag_o === 1'b1);
      n_irq += int'(slip_irq_o === 1'b1);
      if (cycles == 5000) begin
         miscompares++;
         final_report;
      end
   end
   task automatic final_report;
      $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wrreg(input logic [6:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
      host.xfer(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   // Frame, one word clock edge, then count flag and irq pulses
   task automatic slip(input logic [3:0] cfg, input logic on_b,
                       input int ph, input logic [1:0] exp, care);
      int f0, i0;
      {port_a_dir_src_i, port_a_slave_i, port_b_dir_src_i,
       port_b_slave_i} = cfg;
      rx_frame_strobe_i = 1'b1;
      @(posedge mclk_i) #1;
      rx_frame_strobe_i = 1'b0;
      // Baseline, so only pulses of this scenario count
      f0 = n_flag;
      i0 = n_irq;
      repeat (ph) @(posedge mclk_i);
      #1;
      if (on_b) port_b_word_clock_i = ~port_b_word_clock_i;
      else port_a_word_clock_i = ~port_a_word_clock_i;
      repeat (8) @(posedge mclk_i);
      #1;
      chk({6'h00, {n_flag > f0, n_irq > i0} & care}, {6'h00, exp});
   endtask
   initial begin
      {port_a_dir_src_i, port_a_slave_i} = 2'h0;
      {port_b_dir_src_i, port_b_slave_i} = 2'h0;
      repeat (4) @(posedge mclk_i);
      #1;
      rst_b_i = 1'b1;
      rdchk(RSIM_MASK_ONE_ADDR, RSIM_MASK_RST);
      wrreg(RSIM_SLIP_STAT_ADDR, 8'hff);
      rdchk(RSIM_SLIP_STAT_ADDR, 8'h00);
      rdchk(7'h7f, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wrreg(RSIM_MASK_ONE_ADDR, 8'h01 << i);
         stat2_flags_i = 8'hff;
         rdchk(RSIM_MASK_ONE_ADDR, 8'h01 << i);
         chk(stat2_irq_o, 8'h01 << i);
         stat2_flags_i = ~(8'h01 << i);
         rdchk(RSIM_STAT2_ADDR, ~(8'h01 << i));
         chk(stat2_irq_o, 8'h00);
         chk({7'h00, buffer_transfer_done_flag_o}, {7'h00, i != 0});
      end
      slip(4'b1100, 1'b0, 2, 2'b10, 2'b11);
      wrreg(RSIM_MASK_TWO_ADDR, 8'h01);
      rdchk(RSIM_MASK_TWO_ADDR, 8'h01);
      slip(4'b1100, 1'b0, 2, 2'b11, 2'b11);
      slip(4'b1100, 1'b0, 50, 2'b00, 2'b11);
      slip(4'b1100, 1'b0, 5, 2'b11, 2'b11);
      slip(4'b1100, 1'b0, 6, 2'b00, 2'b11);
      slip(4'b1100, 1'b0, 94, 2'b00, 2'b11);
      slip(4'b1100, 1'b0, 95, 2'b11, 2'b11);
      slip(4'b1000, 1'b0, 2, 2'b00, 2'b11);
      slip(4'b0010, 1'b1, 2, 2'b00, 2'b11);
      slip(4'b1111, 1'b1, 2, 2'b00, 2'b11);
      slip(4'b0011, 1'b1, 2, 2'b11, 2'b11);
      slip(4'b1111, 1'b0, 2, 2'b11, 2'b11);
      wrreg(RSIM_MASK_TWO_ADDR, 8'h00);
      slip(4'b1100, 1'b0, 2, 2'b10, 2'b11);
      // Reset in mid-run must bring both masks back to masked
      rst_b_i = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      rst_b_i = 1'b1;
      rdchk(RSIM_MASK_ONE_ADDR, RSIM_MASK_RST);
      rdchk(RSIM_MASK_TWO_ADDR, 8'h00);
      final_report;
   end
endmodule // tb_top
